// file: adcc_assertions.sv
// Concurrent checks on the ports of the converter control block.
// Assumes binding onto adcc_top; inputs mirror its ports by name.
`timescale 1ns/100ps
module adcc_assertions
  import adcc_pkg::*;
#(
  parameter int ADDR_W   = 8,
  parameter int RESULT_W = 10
)(
  // System
  input wire logic        clk_sys,
  input wire logic        srst,
  // Bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // Converter
  input wire logic        global_irq_enable,
  input wire logic        irq_vector_taken,
  input wire logic        irq_request,
  input wire logic        converter_power,
  input wire logic        conversion_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // Length of the current conversion in system clocks
  logic [11:0] run_q;
  always_ff @(posedge clk_sys)
  begin
    if (srst || !conversion_active)
      run_q <= 12'h000;
    else if (run_q != 12'hFFF)
      run_q <= run_q + 12'h001;
  end

  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_conv_end;
    $fell(conversion_active) ##1 converter_power;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_irq_needs_global: assert property (
    irq_request |-> $past(global_irq_enable)) else $error("irq without global enable");
  a_vector_clears_irq: assert property (
    irq_vector_taken && !conversion_active |-> ##2 !irq_request)
    else $error("irq stays after vector");
  a_abort_on_off: assert property (
    $fell(converter_power) |-> ##[0:1] !conversion_active) else $error("no abort on disable");
  a_min_conv_length: assert property (
    s_conv_end |-> $past(run_q) >= 12'd24) else $error("conversion too short");
  a_wr_response: assert property (
    s_wr_take |-> ##2 bvalid) else $error("write response late");
  a_bvalid_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bvalid dropped");
  a_rvalid_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rvalid dropped");
  a_read_latency: assert property (
    arvalid && arready |=> rvalid) else $error("read data late");
  a_rdata_upper_zero: assert property (
    rvalid |-> rdata[31:8] == 24'h000000) else $error("upper read bits set");
endmodule // adcc_assertions

// file: adcc_pkg.sv
// Constants and carrier types for the converter control block.
// Assumes a 32-bit AXI4-Lite master and an analog front end outside.
// Summary of operation
// - Enable bit powers the converter; clearing it aborts a running conversion.
// - Single mode starts one conversion per start write; free-running only the first.
// - First conversion after enabling takes 25 converter clocks, later ones 13.
// - Start bit reads one while converting; writing zero to it does nothing.
// - With auto trigger on, a rising edge of the chosen trigger starts a conversion when none is running.
// - Done flag sets when a conversion ends; the result is stored only if not frozen.
// - Interrupt request is set one clock after done flag, its enable and global enable are all set.
// - Done flag clears when its vector is taken or software writes one to it.
// - Prescale codes 0 and 1 divide by 2, higher codes by 4 up to 128.
// - Differential channels give a two's complement result.
// - After a low byte read the result is frozen until the high byte is read.
// - Right alignment puts bits 9:8 low in high byte; left alignment shifts up.
// - Trigger select acts only with auto trigger on; edge of chosen flag triggers.
// - Switching from a clear source to a set source counts as a rising edge.
// - Selecting free-running code zero never creates a trigger event.
// - Trigger codes 0 to 7 map free run, comparator, ext int 0, timer sources.
// - Reference and channel changes take effect only after the running conversion ends.
// - Alignment changes affect the result bytes immediately.
package adcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADCC_CTRL_OFF   = 8'h00;
  localparam logic [7:0] ADCC_RES_LO_OFF = 8'h04;
  localparam logic [7:0] ADCC_RES_HI_OFF = 8'h08;
  localparam logic [7:0] ADCC_TRIG_OFF   = 8'h0C;
  localparam logic [7:0] ADCC_INSEL_OFF  = 8'h10;

  // Control register fields
  localparam int ADCC_EN_BIT    = 7;
  localparam int ADCC_START_BIT = 6;
  localparam int ADCC_AUTO_BIT  = 5;
  localparam int ADCC_FLAG_BIT  = 4;
  localparam int ADCC_IE_BIT    = 3;
  localparam int ADCC_PS_LSB    = 0;
  // Trigger register field
  localparam int ADCC_TS_LSB    = 5;
  // Input select register fields
  localparam int ADCC_REF_LSB   = 6;
  localparam int ADCC_ALIGN_BIT = 5;
  localparam int ADCC_MUX_LSB   = 0;

  // Reset values
  localparam logic [7:0] ADCC_CTRL_RST   = 8'h00;
  localparam logic [7:0] ADCC_TRIG_RST   = 8'h00;
  localparam logic [7:0] ADCC_INSEL_RST  = 8'h00;
  localparam logic [9:0] ADCC_RESULT_RST = 10'h000;

  // Conversion length in converter clock cycles
  localparam logic [4:0] ADCC_FIRST_CYCLES  = 5'h19;
  localparam logic [4:0] ADCC_NORMAL_CYCLES = 5'h0D;

  // Trigger and channel codes
  localparam logic [2:0] ADCC_TS_FREE_RUN = 3'h0;
  localparam logic [4:0] ADCC_DIFF_FIRST  = 5'h08;
  localparam logic [4:0] ADCC_DIFF_LAST   = 5'h1D;

  // AXI responses
  localparam logic [1:0] ADCC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ADCC_RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger flags, bit index equals trigger code (bit 0 unused)
  typedef struct packed {
    logic t1_capture;
    logic t1_overflow;
    logic t1_compare_b;
    logic t0_overflow;
    logic t0_compare;
    logic ext_int0;
    logic comparator;
    logic unused0;
  } adcc_trig_type;

  typedef struct packed {
    logic [1:0] reference_select;
    logic [4:0] channel_gain_select;
  } adcc_mux_type;

endpackage

// file: adcc_top.sv
// Converter control, prescaler, result and AXI4-Lite register slave.
// Assumes trigger flags and cpu signals come from logic on clk_sys.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int ADDR_W   = 8,
  parameter int RESULT_W = 10
)(
  // System
  input  wire logic                clk_sys,
  input  wire logic                srst,
  input  wire logic                ce,
  // AXI4-Lite write
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]          awprot,
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output logic                     bvalid,
  input  wire logic                bready,
  output logic [1:0]               bresp,
  // AXI4-Lite read
  input  wire logic                arvalid,
  output logic                     arready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic [2:0]          arprot,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  // Trigger sources and cpu
  input  adcc_trig_type            trig_flags,
  input  wire logic                global_irq_enable,
  input  wire logic                irq_vector_taken,
  output logic                     irq_request,
  // Analog front end
  input  wire logic [RESULT_W-1:0] sample_value,
  output logic                     converter_power,
  output logic                     conversion_active,
  output adcc_mux_type             mux_active
);

  if (RESULT_W != 10) begin : g_bad_width
    $error("adcc_top supports RESULT_W of 10 only");
  end
  if (ADDR_W < 5) begin : g_bad_addr
    $error("adcc_top needs ADDR_W of at least 5");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic                en_q;
  logic                auto_q;
  logic                flag_q;
  logic                ie_q;
  logic [2:0]          ps_q;
  logic [2:0]          ts_q;
  logic [7:0]          insel_q;
  logic [RESULT_W-1:0] result_q;
  logic                lock_q;
  logic                busy_q;
  logic                first_q;
  logic [4:0]          conv_cnt_q;
  logic [6:0]          div_cnt_q;
  logic                trig_prev_q;
  logic                irq_q;
  adcc_mux_type        mux_q;

  // Bus state
  logic                aw_have_q;
  logic                w_have_q;
  logic [ADDR_W-1:0]   waddr_q;
  logic [7:0]          wbyte_q;
  logic                wlane_q;
  logic                awready_q;
  logic                wready_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                arready_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic       reg_wr;
  logic       wr_ctrl;
  logic       wr_trig;
  logic       wr_insel;
  logic       wr_mapped;
  logic       rd_go;
  logic       rd_mapped;
  logic       en_next;
  logic       tick;
  logic [6:0] div_last;
  logic [4:0] conv_last;
  logic       done;
  logic       trig_sel;
  logic       trig_edge;
  logic       sw_start;
  logic       free_next;
  logic       start_go;
  logic       diff_sel;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_byte;
  adcc_trig_type trig_now;

  always_comb
  begin
    reg_wr    = aw_have_q && w_have_q && !bvalid_q && wlane_q;
    wr_ctrl   = reg_wr && waddr_q == ADDR_W'(ADCC_CTRL_OFF);
    wr_trig   = reg_wr && waddr_q == ADDR_W'(ADCC_TRIG_OFF);
    wr_insel  = reg_wr && waddr_q == ADDR_W'(ADCC_INSEL_OFF);
    wr_mapped = waddr_q == ADDR_W'(ADCC_CTRL_OFF)
             || waddr_q == ADDR_W'(ADCC_TRIG_OFF)
             || waddr_q == ADDR_W'(ADCC_INSEL_OFF)
             || waddr_q == ADDR_W'(ADCC_RES_LO_OFF)
             || waddr_q == ADDR_W'(ADCC_RES_HI_OFF);
    rd_go     = arvalid && arready_q;
    rd_mapped = araddr == ADDR_W'(ADCC_CTRL_OFF)
             || araddr == ADDR_W'(ADCC_TRIG_OFF)
             || araddr == ADDR_W'(ADCC_INSEL_OFF)
             || araddr == ADDR_W'(ADCC_RES_LO_OFF)
             || araddr == ADDR_W'(ADCC_RES_HI_OFF);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and conversion timing
  always_comb
  begin
    en_next = wr_ctrl ? wbyte_q[ADCC_EN_BIT] : en_q;
    if (ps_q < 3'h2)
      div_last = 7'h01;
    else
      div_last = 7'((8'h01 << ps_q) - 8'h01);
    tick      = en_q && div_cnt_q == div_last;
    conv_last = (first_q ? ADCC_FIRST_CYCLES : ADCC_NORMAL_CYCLES) - 5'h01;
    done      = busy_q && tick && conv_cnt_q == conv_last;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      div_cnt_q <= '0;
    else if (ce)
    begin
      if (!en_q || tick)
        div_cnt_q <= '0;
      else
        div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Triggering
  always_comb
  begin
    trig_now  = trig_flags;
    // Code zero reads as a constant low source
    trig_sel  = (ts_q == ADCC_TS_FREE_RUN) ? 1'b0 : trig_now[ts_q];
    trig_edge = auto_q && trig_sel && !trig_prev_q;
    sw_start  = wr_ctrl && wbyte_q[ADCC_START_BIT];
    free_next = done && auto_q && ts_q == ADCC_TS_FREE_RUN;
    start_go  = en_next && (!busy_q || done)
             && (sw_start || trig_edge || free_next);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      trig_prev_q <= 1'b0;
    else if (ce)
      trig_prev_q <= trig_sel;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      busy_q     <= 1'b0;
      first_q    <= 1'b1;
      conv_cnt_q <= '0;
    end
    else if (ce)
    begin
      if (!en_next)
      begin
        busy_q     <= 1'b0;
        first_q    <= 1'b1;
        conv_cnt_q <= '0;
      end
      else if (start_go)
      begin
        busy_q     <= 1'b1;
        conv_cnt_q <= '0;
        first_q    <= first_q && !done;
      end
      else if (done)
      begin
        busy_q     <= 1'b0;
        first_q    <= 1'b0;
        conv_cnt_q <= '0;
      end
      else if (busy_q && tick)
        conv_cnt_q <= conv_cnt_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      en_q   <= ADCC_CTRL_RST[ADCC_EN_BIT];
      auto_q <= ADCC_CTRL_RST[ADCC_AUTO_BIT];
      ie_q   <= ADCC_CTRL_RST[ADCC_IE_BIT];
      ps_q   <= ADCC_CTRL_RST[ADCC_PS_LSB +: 3];
    end
    else if (ce && wr_ctrl)
    begin
      en_q   <= wbyte_q[ADCC_EN_BIT];
      auto_q <= wbyte_q[ADCC_AUTO_BIT];
      ie_q   <= wbyte_q[ADCC_IE_BIT];
      ps_q   <= wbyte_q[ADCC_PS_LSB +: 3];
    end
  end

  // Done flag: a completion in the clearing cycle wins
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      flag_q <= ADCC_CTRL_RST[ADCC_FLAG_BIT];
    else if (ce)
    begin
      if (done)
        flag_q <= 1'b1;
      else if (irq_vector_taken || (wr_ctrl && wbyte_q[ADCC_FLAG_BIT]))
        flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      irq_q <= 1'b0;
    else if (ce)
      irq_q <= flag_q && ie_q && global_irq_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger and input select registers
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      ts_q <= ADCC_TRIG_RST[ADCC_TS_LSB +: 3];
    else if (ce && wr_trig)
      ts_q <= wbyte_q[ADCC_TS_LSB +: 3];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      insel_q <= ADCC_INSEL_RST;
    else if (ce && wr_insel)
      insel_q <= wbyte_q;
  end

  // Selection reaches the front end only between conversions
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      mux_q <= adcc_mux_type'({ADCC_INSEL_RST[ADCC_REF_LSB +: 2],
                               ADCC_INSEL_RST[ADCC_MUX_LSB +: 5]});
    else if (ce && (!busy_q || done))
    begin
      mux_q.reference_select    <= insel_q[ADCC_REF_LSB +: 2];
      mux_q.channel_gain_select <= insel_q[ADCC_MUX_LSB +: 5];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result capture and lock
  always_comb
  begin
    diff_sel = mux_q.channel_gain_select >= ADCC_DIFF_FIRST
            && mux_q.channel_gain_select <= ADCC_DIFF_LAST;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      result_q <= ADCC_RESULT_RST;
    else if (ce && done && !lock_q)
    begin
      if (diff_sel)
        result_q <= {~sample_value[RESULT_W-1], sample_value[RESULT_W-2:0]};
      else
        result_q <= sample_value;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      lock_q <= 1'b0;
    else if (ce && rd_go)
    begin
      if (araddr == ADDR_W'(ADCC_RES_LO_OFF))
        lock_q <= 1'b1;
      else if (araddr == ADDR_W'(ADCC_RES_HI_OFF))
        lock_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb
  begin
    if (insel_q[ADCC_ALIGN_BIT])
    begin
      res_hi = result_q[9:2];
      res_lo = {result_q[1:0], 6'h00};
    end
    else
    begin
      res_hi = {6'h00, result_q[9:8]};
      res_lo = result_q[7:0];
    end
    ctrl_rd = '0;
    ctrl_rd[ADCC_EN_BIT]       = en_q;
    ctrl_rd[ADCC_START_BIT]    = busy_q;
    ctrl_rd[ADCC_AUTO_BIT]     = auto_q;
    ctrl_rd[ADCC_FLAG_BIT]     = flag_q;
    ctrl_rd[ADCC_IE_BIT]       = ie_q;
    ctrl_rd[ADCC_PS_LSB +: 3]  = ps_q;
    rd_byte = '0;
    if (araddr == ADDR_W'(ADCC_CTRL_OFF))
      rd_byte = ctrl_rd;
    else if (araddr == ADDR_W'(ADCC_RES_LO_OFF))
      rd_byte = res_lo;
    else if (araddr == ADDR_W'(ADCC_RES_HI_OFF))
      rd_byte = res_hi;
    else if (araddr == ADDR_W'(ADCC_TRIG_OFF))
      rd_byte = {ts_q, 5'h00};
    else if (araddr == ADDR_W'(ADCC_INSEL_OFF))
      rd_byte = insel_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      waddr_q   <= '0;
      wbyte_q   <= '0;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= ADCC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready_q)
      begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        waddr_q   <= awaddr;
      end
      if (wvalid && wready_q)
      begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wbyte_q  <= wdata[7:0];
        wlane_q  <= wstrb[0];
      end
      if (aw_have_q && w_have_q && !bvalid_q)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_mapped ? ADCC_RESP_OKAY : ADCC_RESP_SLVERR;
      end
      if (bvalid_q && bready)
      begin
        bvalid_q  <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= ADCC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_go)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= {24'h000000, rd_byte};
        rresp_q   <= rd_mapped ? ADCC_RESP_OKAY : ADCC_RESP_SLVERR;
      end
      else if (rvalid_q && rready)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb
  begin
    awready           = awready_q;
    wready            = wready_q;
    bvalid            = bvalid_q;
    bresp             = bresp_q;
    arready           = arready_q;
    rvalid            = rvalid_q;
    rdata             = rdata_q;
    rresp             = rresp_q;
    irq_request       = irq_q;
    converter_power   = en_q;
    conversion_active = busy_q;
    mux_active        = mux_q;
  end

endmodule // adcc_top

// file: adcc_top_tb_top.sv
// Self-checking bench for the converter control block over AXI4-Lite.
// Assumes adcc_pkg and adcc_assertions are compiled first.
`timescale 1ns/100ps
module adcc_top_tb_top;
  import adcc_pkg::*;
  logic          clk_sys = 1'b0;
  logic          srst = 1'b1;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]   wdata = 32'h00000000;
  logic          awready, wready, bvalid, arready, rvalid, irq_request;
  logic [1:0]    bresp, rresp, rsp;
  logic [31:0]   rdata, rd;
  adcc_trig_type trig_flags = '0;
  logic          global_irq_enable = 1'b0, irq_vector_taken = 1'b0;
  logic [9:0]    sample_value = 10'h2A5;
  logic          converter_power, conversion_active;
  adcc_mux_type  mux_active;
  int            err_total = 0;
  int            samples_checked = 0;
  int            len, i, dv;

  adcc_top u_adcc_top (.clk_sys, .srst, .ce(1'b1), .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .trig_flags, .global_irq_enable, .irq_vector_taken, .irq_request, .sample_value,
    .converter_power, .conversion_active, .mux_active);

  always #50 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ck1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic hang();
    err_total++;
    results();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int   n;
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50 && (pa || pw); n++)
    begin
      @(negedge clk_sys);
      if (awready === 1'b1) pa = 1'b0;
      if (wready === 1'b1) pw = 1'b0;
      @(posedge clk_sys);
      awvalid <= pa;
      wvalid <= pw;
      bready <= !(pa || pw);
    end
    for (n = 0; n < 50; n++)
    begin
      @(negedge clk_sys);
      if (bvalid === 1'b1) break;
    end
    if (n == 50) hang();
    rsp = bresp;
    @(posedge clk_sys);
    bready <= 1'b0;
    // Return away from the edge so callers see settled outputs
    @(negedge clk_sys);
  endtask

  task automatic rdx(input logic [7:0] a);
    int n;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge clk_sys);
      if (arready === 1'b1) break;
    end
    @(posedge clk_sys);
    arvalid <= 1'b0;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge clk_sys);
      if (rvalid === 1'b1) break;
    end
    if (n == 50) hang();
    rd = rdata;
    rsp = rresp;
    @(posedge clk_sys);
    rready <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rdx(a);
    check(rd, {24'h000000, e});
    check({30'h0, rsp}, {30'h0, ADCC_RESP_OKAY});
  endtask

  // Waits at negedges until the busy output shows lvl; len counts the cycles
  task automatic wait_act(input logic lvl);
    for (len = 0; len < 4000; len++)
    begin
      @(negedge clk_sys);
      if (conversion_active === lvl) break;
    end
    if (len == 4000) hang();
  endtask

  task automatic pulse_trig(input int code);
    @(posedge clk_sys);
    trig_flags <= adcc_trig_type'(8'(1 << code));
    cyc(5);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    for (i = 0; i < 5; i++) rdc(8'(4 * i), 8'h00);
    rdx(8'h14);
    check({30'h0, rsp}, {30'h0, ADCC_RESP_SLVERR});
    wr(8'h14, 8'hFF);
    check({30'h0, rsp}, {30'h0, ADCC_RESP_SLVERR});
    // First conversion after enabling
    wr(ADCC_CTRL_OFF, 8'hC0);
    rdc(ADCC_CTRL_OFF, 8'hC0);
    wait_act(1'b0);
    check(32'(len >= 42 && len <= 54), 32'h1);
    rdc(ADCC_CTRL_OFF, 8'h90);
    wr(ADCC_CTRL_OFF, 8'h90);
    rdc(ADCC_CTRL_OFF, 8'h80);
    for (i = 0; i < 8; i++)
    begin
      dv = (i < 2) ? 2 : (1 << i);
      wr(ADCC_CTRL_OFF, 8'hC0 | 8'(i));
      wait_act(1'b1);
      wait_act(1'b0);
      check(32'(len >= 12 * dv - 4 && len <= 14 * dv + 2), 32'h1);
    end
    rdc(ADCC_RES_LO_OFF, 8'hA5);
    rdc(ADCC_RES_HI_OFF, 8'h02);
    wr(ADCC_INSEL_OFF, 8'h20);
    rdc(ADCC_RES_HI_OFF, 8'hA9);
    rdc(ADCC_RES_LO_OFF, 8'h40);
    wr(ADCC_INSEL_OFF, 8'h00);
    // Low byte read holds the result until the high byte is read
    rdc(ADCC_RES_LO_OFF, 8'hA5);
    sample_value <= 10'h155;
    wr(ADCC_CTRL_OFF, 8'hC0);
    wait_act(1'b0);
    rdc(ADCC_RES_HI_OFF, 8'h02);
    wr(ADCC_CTRL_OFF, 8'hC0);
    wait_act(1'b0);
    rdc(ADCC_RES_LO_OFF, 8'h55);
    rdc(ADCC_RES_HI_OFF, 8'h01);
    // Differential channel, selection change while busy
    wr(ADCC_INSEL_OFF, 8'h08);
    check({25'h0, mux_active}, 32'h08);
    wr(ADCC_CTRL_OFF, 8'hC0);
    wr(ADCC_INSEL_OFF, 8'h01);
    wr(ADCC_CTRL_OFF, 8'h80);
    ck1(conversion_active, 1'b1);
    check({25'h0, mux_active}, 32'h08);
    wait_act(1'b0);
    cyc(2);
    check({25'h0, mux_active}, 32'h01);
    rdc(ADCC_RES_LO_OFF, 8'h55);
    rdc(ADCC_RES_HI_OFF, 8'h03);
    wr(ADCC_INSEL_OFF, 8'h00);
    // Interrupt request gating and clearing
    wr(ADCC_CTRL_OFF, 8'h88);
    cyc(3);
    ck1(irq_request, 1'b0);
    @(posedge clk_sys);
    global_irq_enable <= 1'b1;
    cyc(3);
    ck1(irq_request, 1'b1);
    @(posedge clk_sys);
    irq_vector_taken <= 1'b1;
    @(posedge clk_sys);
    irq_vector_taken <= 1'b0;
    cyc(3);
    ck1(irq_request, 1'b0);
    wr(ADCC_CTRL_OFF, 8'hC8);
    wait_act(1'b0);
    cyc(2);
    ck1(irq_request, 1'b1);
    wr(ADCC_CTRL_OFF, 8'h98);
    rdc(ADCC_CTRL_OFF, 8'h88);
    ck1(irq_request, 1'b0);
    // Every trigger source
    wr(ADCC_CTRL_OFF, 8'hA0);
    for (i = 1; i < 8; i++)
    begin
      wr(ADCC_TRIG_OFF, 8'(i << 5));
      pulse_trig(i);
      ck1(conversion_active, 1'b1);
      wait_act(1'b0);
      @(posedge clk_sys);
      trig_flags <= '0;
    end
    wr(ADCC_TRIG_OFF, 8'h40);
    pulse_trig(3);
    ck1(conversion_active, 1'b0);
    wr(ADCC_TRIG_OFF, 8'h60);
    cyc(3);
    ck1(conversion_active, 1'b1);
    wait_act(1'b0);
    wr(ADCC_CTRL_OFF, 8'h80);
    @(posedge clk_sys);
    trig_flags <= '0;
    wr(ADCC_TRIG_OFF, 8'h20);
    pulse_trig(1);
    ck1(conversion_active, 1'b0);
    wr(ADCC_TRIG_OFF, 8'hEF);
    rdc(ADCC_TRIG_OFF, 8'hE0);
    @(posedge clk_sys);
    trig_flags <= '0;
    wr(ADCC_CTRL_OFF, 8'hA0);
    wr(ADCC_TRIG_OFF, 8'h00);
    cyc(5);
    ck1(conversion_active, 1'b0);
    // Free running, then abort by disabling
    wr(ADCC_CTRL_OFF, 8'hE0);
    cyc(90);
    rdc(ADCC_CTRL_OFF, 8'hF0);
    wr(ADCC_CTRL_OFF, 8'h00);
    wait_act(1'b0);
    ck1(converter_power, 1'b0);
    rdc(ADCC_CTRL_OFF, 8'h10);
    results();
  end
endmodule // adcc_top_tb_top

bind adcc_top adcc_assertions #(.ADDR_W(ADDR_W), .RESULT_W(RESULT_W)) u_adcc_assertions (
  .clk_sys, .srst, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp,
  .arvalid, .arready, .rvalid, .rready, .rdata, .global_irq_enable, .irq_vector_taken,
  .irq_request, .converter_power, .conversion_active);
